// ### rtl/hpsc_pkg.sv
// Constants, register map and carrier types of the hot plug power sequencer controller
package hpsc_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int T_SHORT_NS     = 10000;  // Short reset interval, 10 us
    localparam int T_LONG_NS      = 120000; // Breaker reset interval, 120 us
    // Least times round up; one more cycle makes the low phase strictly longer
    localparam int SHORT_CYC      = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int LONG_CYC       = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int CNT_W          = 12;

    // AXI4-Lite register map (byte addresses)
    localparam int ADDR_W         = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CMD    = 4'h8;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_TRIP_BIT   = 1;
    localparam int CTRL_PG_BIT     = 2;
    // Command register fields (write-only pulses)
    localparam int CMD_SHORT_BIT   = 0;
    localparam int CMD_LONG_BIT    = 1;
    // Status register fields
    localparam int ST_ON_BIT       = 0;
    localparam int ST_FAULT_BIT    = 1;
    localparam int ST_BUSY_BIT     = 2;
    localparam int ST_TRIP_BIT     = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic pg_drive;
        logic ext_trip;
        logic enable;
    } hpsc_ctrl_t;

    typedef struct packed {
        logic tripped;
        logic busy;
        logic fault_low;
        logic on_level;
    } hpsc_status_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } hpsc_state_t;

endpackage

// ### rtl/hpsc_sync.sv
// Two flip-flop synchroniser for pin levels entering the aclk domain
`timescale 1ns/100ps
module hpsc_sync #(
    parameter int          WIDTH    = 1,
    parameter logic        RST_VAL  = 1'b1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("hpsc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{RST_VAL}};
            dout   <= {WIDTH{RST_VAL}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ### rtl/hpsc_ctrl.sv
// Host controller that sequences the on line and watches the breaker fault line
`timescale 1ns/100ps
module hpsc_ctrl
    import hpsc_pkg::*;
#(
    parameter int SHORT_CYCLES = SHORT_CYC,
    parameter int LONG_CYCLES  = LONG_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   dev_on,
    input  wire logic              fault_in,
    output logic                   fault_out,
    output logic                   fault_oe,
    output logic                   converter_good_output
);

    if (SHORT_CYCLES < 1 || LONG_CYCLES <= SHORT_CYCLES || LONG_CYCLES >= (1 << CNT_W))
    begin : g_chk
        $error("hpsc_ctrl: cycle counts out of range");
    end

    localparam logic [CNT_W-1:0] SHORT_N = CNT_W'(SHORT_CYCLES);
    localparam logic [CNT_W-1:0] LONG_N  = CNT_W'(LONG_CYCLES);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    hpsc_ctrl_t       ctrl_q;
    hpsc_state_t      state_q;
    logic [CNT_W-1:0] low_len_q;
    logic [CNT_W-1:0] target_q;
    logic             tripped_q;
    logic             fault_s;
    logic             aw_hold_q;
    logic             w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             wr_go;
    logic             cmd_short;
    logic             cmd_long;
    logic             trip_clear;
    hpsc_status_t     status;

    // Word index decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        if (a == OFS_CTRL)
            return 2'h1;
        else if (a == OFS_STATUS)
            return 2'h2;
        else if (a == OFS_CMD)
            return 2'h3;
        else
            return 2'h0;
    endfunction

    // Fault line is a pin, so it is synchronised before any use
    hpsc_sync #(
        .WIDTH   (1),
        .RST_VAL (1'b1)
    ) u_fault_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (fault_in),
        .dout    (fault_s)
    );

    // Write channel: address and data taken in either order
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (reg_sel(awaddr_q) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Decoded write effects; only byte lane 0 carries fields
    assign cmd_short  = wr_go && wstrb_q[0] && reg_sel(awaddr_q) == 2'h3
                        && wdata_q[CMD_SHORT_BIT];
    assign cmd_long   = wr_go && wstrb_q[0] && reg_sel(awaddr_q) == 2'h3
                        && wdata_q[CMD_LONG_BIT];
    assign trip_clear = wr_go && wstrb_q[0] && reg_sel(awaddr_q) == 2'h2
                        && wdata_q[ST_TRIP_BIT];

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= hpsc_ctrl_t'(CTRL_RESET[2:0]);
        end else if (wr_go && wstrb_q[0] && reg_sel(awaddr_q) == 2'h1) begin
            ctrl_q.enable   <= wdata_q[CTRL_ENABLE_BIT];
            ctrl_q.ext_trip <= wdata_q[CTRL_TRIP_BIT];
            ctrl_q.pg_drive <= wdata_q[CTRL_PG_BIT];
        end
    end

    // Sequencer: on line rises only after the chosen low time has passed.
    // A long low on the on line is the only way to clear a latched breaker, so a restart
    // after a trip is software's choice, never automatic.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q  <= ST_IDLE;
            dev_on   <= 1'b0;
            target_q <= LONG_N;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_long) begin
                        target_q <= LONG_N;
                    end else if (cmd_short) begin
                        // A short command restarts the count but never cuts a
                        // pending breaker reset wait, nor raises the line itself
                        if (target_q != LONG_N)
                            target_q <= SHORT_N;
                    end else if (ctrl_q.enable && low_len_q >= target_q) begin
                        state_q  <= ST_RUN;
                        dev_on   <= 1'b1;
                        target_q <= SHORT_N;
                    end
                end
                ST_RUN: begin
                    if (cmd_long || cmd_short || !ctrl_q.enable) begin
                        state_q  <= ST_IDLE;
                        dev_on   <= 1'b0;
                        target_q <= cmd_long ? LONG_N : SHORT_N;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    dev_on  <= 1'b0;
                end
            endcase
        end
    end

    // Low time of the on line, saturating; restarts on every command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_len_q <= '0;
        end else if (dev_on || cmd_long || cmd_short) begin
            low_len_q <= '0;
        end else if (low_len_q != CNT_MAX) begin
            low_len_q <= low_len_q + CNT_W'(1);
        end
    end

    // Trip seen on the fault line; a new low beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tripped_q <= 1'b0;
        end else if (!fault_s) begin
            tripped_q <= 1'b1;
        end else if (trip_clear) begin
            tripped_q <= 1'b0;
        end
    end

    // Pin drivers: fault is open drain, so only the enable ever moves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_out             <= 1'b0;
            fault_oe              <= 1'b0;
            converter_good_output <= 1'b0;
        end else begin
            fault_out             <= 1'b0;
            fault_oe              <= ctrl_q.ext_trip;
            converter_good_output <= ctrl_q.pg_drive;
        end
    end

    // Status view
    always_comb begin
        status.on_level  = dev_on;
        status.fault_low = !fault_s;
        status.busy      = (state_q == ST_IDLE) && ctrl_q.enable;
        status.tripped   = tripped_q;
    end

    // Read channel: one read under way; answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (reg_sel(s_axi_araddr))
                    2'h1:    s_axi_rdata <= {29'h0, ctrl_q};
                    2'h2:    s_axi_rdata <= {28'h0, status};
                    2'h3:    s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Assertions and coverage
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic long_pend_q;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            long_pend_q <= 1'b1;
        else if (cmd_long)
            long_pend_q <= 1'b1;
        else if (dev_on)
            long_pend_q <= 1'b0;
    end

    AST_ON_NEEDS_ENABLE: assert property ($rose(dev_on) |-> $past(ctrl_q.enable))
        else $error("On line rose while disabled");
    AST_ON_SHORT_LOW: assert property ($rose(dev_on) |-> $past(low_len_q) >= SHORT_N)
        else $error("On line low time shorter than short interval");
    AST_ON_LONG_LOW: assert property ($rose(dev_on) && $past(long_pend_q)
        |-> $past(low_len_q) >= LONG_N)
        else $error("Breaker reset low time too short");
    AST_EXT_TRIP: assert property (ctrl_q.ext_trip |=> fault_oe && !fault_out)
        else $error("External trip not driven on fault line");
    AST_PG_FOLLOW: assert property ($changed(ctrl_q.pg_drive)
        |=> converter_good_output == $past(ctrl_q.pg_drive))
        else $error("Converter good output did not follow control");
    AST_TRIP_STICKY: assert property (tripped_q && !trip_clear |=> tripped_q)
        else $error("Trip flag lost without clear");
    AST_RESTART_DROP: assert property (dev_on && cmd_long |=> !dev_on ##1 !dev_on[*3])
        else $error("Restart did not drop on line");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("Read data dropped early");
    AST_FAULT_TRIP: assert property (!fault_s |=> tripped_q)
        else $error("Fault low not recorded");

    // Unmapped words answer with an error response
    AST_WR_UNMAPPED: assert property (wr_go && reg_sel(awaddr_q) == 2'h0
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("Unmapped write not refused");
    // Clearing enable must drop the on line at the next edge
    AST_DISABLE_DROP: assert property (dev_on && !ctrl_q.enable |=> !dev_on)
        else $error("On line stayed high while disabled");
    // Open drain pin: the data side never carries a high
    AST_FAULT_OD: assert property (!fault_out)
        else $error("Fault line driven high");
    // A short command during a breaker reset wait leaves the long wait in place
    AST_KEEP_LONG: assert property (cmd_short && target_q == LONG_N
        |=> target_q == LONG_N)
        else $error("Short command cut a breaker reset wait");

    COV_POWER_UP:  cover property ($rose(dev_on));
    COV_TRIP:      cover property ($rose(tripped_q) ##[1:1000] trip_clear);
    COV_RESTART:   cover property (dev_on && cmd_long ##[1:1000] $rose(dev_on));
    COV_EXT_TRIP:  cover property ($rose(fault_oe));
    COV_SHORT:     cover property (dev_on && cmd_short ##[1:1000] $rose(dev_on));

endmodule

// ### sim/hpsc_dev_model.sv
// Behavioural model of the sequenced power switch device beyond the controller
`timescale 1ns/100ps
// Capacitor delays and comparator qualification are cycle counts here
// Overcurrent and supply lockout never occur on this bench
module hpsc_dev_model #(
    parameter int OFF_CYC  = 3,
    parameter int RST_CYC  = 9,
    parameter int TMR_CYC  = 6,
    parameter int TOUT_CYC = 4,
    parameter int TOUT_NUM = 14,
    parameter int FILT_CYC = 12
) (
    input  wire logic aclk,
    input  wire logic on_in,
    input  wire logic pg_in,
    input  wire logic fault_lvl,
    output logic      fault_pull,
    output logic      gate_on,
    output logic      pwr_ok
);
    logic [2:0]  st_q   = 3'h0;
    logic [15:0] cnt_q  = 16'h0;
    logic [15:0] low_q  = 16'h0;
    logic        trip_q = 1'b0;

    // Sequencer; the breaker latch outlives a short low on the on line
    always_ff @(posedge aclk) begin
        if (!on_in) begin
            low_q <= low_q + 16'h1;
            if (low_q >= OFF_CYC) begin
                st_q  <= 3'h0;
                cnt_q <= 16'h0;
            end
            if (low_q >= RST_CYC) trip_q <= 1'b0;
        end else begin
            low_q <= 16'h0;
            cnt_q <= cnt_q + 16'h1;
            if (!fault_lvl || trip_q) begin
                trip_q <= 1'b1;
                st_q   <= 3'h0;
            end else begin
                case (st_q)
                3'h0: cnt_q <= 16'h0;
                3'h1, 3'h2: if (cnt_q >= TMR_CYC - 1) begin
                    st_q  <= st_q + 3'h1;
                    cnt_q <= 16'h0;
                end
                3'h3: if (cnt_q >= TOUT_CYC * TOUT_NUM - 1) begin
                    cnt_q  <= 16'h0;
                    st_q   <= pg_in ? 3'h4 : 3'h3;
                    trip_q <= !pg_in;
                end
                default: begin
                    cnt_q <= pg_in ? 16'h0 : cnt_q + 16'h1;
                    if (cnt_q >= FILT_CYC) trip_q <= 1'b1;
                end
                endcase
                if (st_q == 3'h0) st_q <= 3'h1;
            end
        end
    end

    // Open-drain pull and gate follow the latch directly
    assign fault_pull = trip_q;
    assign gate_on    = (st_q >= 3'h2) && !trip_q;
    assign pwr_ok     = (st_q == 3'h4) && !trip_q;
endmodule

// ### sim/tb.sv
// Self-checking bench: register tasks drive the controller against the device model
`timescale 1ns/100ps
module tb;
    import hpsc_pkg::*;
    localparam int SHORT_N = 4;
    localparam int LONG_N  = 10;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        dev_on, fault_out, fault_oe, pg, fault_w, dev_pull, gate_on, pwr_ok;
    int          err_total = 0, samples_checked = 0, cyc = 0, lowc = 0, need = LONG_N, t0;

    always #20 aclk = ~aclk;
    // Wire has a pull-up; it is low while either party pulls it
    assign fault_w = ~((fault_oe & ~fault_out) | dev_pull);

    hpsc_ctrl #(.SHORT_CYCLES(SHORT_N), .LONG_CYCLES(LONG_N)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dev_on(dev_on), .fault_in(fault_w), .fault_out(fault_out), .fault_oe(fault_oe),
        .converter_good_output(pg));
    hpsc_dev_model dev (.aclk(aclk), .on_in(dev_on), .pg_in(pg), .fault_lvl(fault_w),
        .fault_pull(dev_pull), .gate_on(gate_on), .pwr_ok(pwr_ok));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata & m, e, "read data");
        chk({30'h0, rresp}, {30'h0, er}, "read response");
    endtask

    // Bounded wait on dev_on (0), fault wire (1) or device power ok (2)
    task automatic ws(input int which, input logic val, input int lim);
        logic [2:0] v;
        v = {pwr_ok, fault_w, dev_on};
        for (int i = 0; i < lim && v[which] !== val; i++) begin
            @(posedge aclk);
            v = {pwr_ok, fault_w, dev_on};
        end
        chk({31'h0, v[which]}, {31'h0, val}, "pin level after wait");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            close_out();
        end
    end

    // The on line must stay low long enough before each rise
    always @(posedge aclk) begin
        if (aresetn && dev_on === 1'b0) lowc <= lowc + 1;
        if (dev_on === 1'b1 && lowc != 0) begin
            chk(32'(lowc >= need), 32'h1, "on line low time");
            lowc <= 0;
            need = SHORT_N;
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped word refused
        rd(OFS_CTRL, ALL, 32'h0, RESP_OKAY);
        rd(OFS_STATUS, ALL, 32'h0, RESP_OKAY);
        rd(OFS_CMD, ALL, 32'h0, RESP_OKAY);
        rd(4'hc, ALL, 32'h0, RESP_SLVERR);
        wr(4'hc, 32'h1, RESP_SLVERR);
        rd(OFS_CTRL, ALL, 32'h0, RESP_OKAY);
        $display("test registers done");
        // Power-up with power good present, then a glitch shorter than the filter
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        ws(2, 1'b1, 400);
        rd(OFS_STATUS, ALL, 32'h1, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk({31'h0, pwr_ok}, 32'h1, "glitch ignored");
        $display("test glitch done");
        // Sustained loss trips and latches; short cycle keeps it latched
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        ws(1, 1'b0, 100);
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, ALL, 32'hb, RESP_OKAY);
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        ws(0, 1'b0, 10);
        ws(0, 1'b1, 100);
        rd(OFS_STATUS, ALL, 32'hb, RESP_OKAY);
        chk({31'h0, gate_on}, 32'h0, "gate stays off");
        $display("test trip done");
        // Long cycle clears the breaker; power good stays low so time-out trips
        need = LONG_N;
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        rd(OFS_STATUS, 32'h5, 32'h4, RESP_OKAY);
        ws(0, 1'b1, 100);
        t0 = cyc;
        wr(OFS_STATUS, 32'h8, RESP_OKAY);
        rd(OFS_STATUS, ALL, 32'h1, RESP_OKAY);
        ws(1, 1'b0, 300);
        chk(32'(cyc - t0 >= 68), 32'h1, "time-out length");
        chk({31'h0, pwr_ok}, 32'h0, "no power ok");
        $display("test timeout done");
        // External pull of the fault wire acts like an internal trip
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        need = LONG_N;
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        ws(0, 1'b1, 100);
        wr(OFS_STATUS, 32'h8, RESP_OKAY);
        ws(2, 1'b1, 400);
        wr(OFS_CTRL, 32'h7, RESP_OKAY);
        ws(2, 1'b0, 20);
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, ALL, 32'hb, RESP_OKAY);
        $display("test external done");
        // Disable drops the on line; a long low frees the wire, trip flag stays
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        ws(0, 1'b0, 10);
        ws(1, 1'b1, 100);
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, ALL, 32'h8, RESP_OKAY);
        wr(OFS_STATUS, 32'h8, RESP_OKAY);
        rd(OFS_STATUS, ALL, 32'h0, RESP_OKAY);
        $display("test disable done");
        close_out();
    end
endmodule
